// >>> include/tbd_pkg.sv
/*
  Shared constants and types for the tick timer and buzzer divider block:
  register index and byte address, field layout of the control register,
  reset value and the divider tap exponents.
  Assumes a 32-bit APB register bus and one system clock.
*/
package tbd_pkg;

  // The printed offset is not a word multiple, so it is kept as an index
  localparam logic [7:0] TBD_CTRL_INDEX = 8'h36;
  localparam logic [9:0] TBD_CTRL_ADDR  = {TBD_CTRL_INDEX, 2'b00};

  localparam logic [7:0] TBD_CTRL_RESET = 8'h00;

  // Field positions, bit 7 down to bit 0
  localparam int TBD_BUZZ_EN_POS   = 7;
  localparam int TBD_BUZZ_RATE_POS = 5;
  localparam int TBD_PRESCALE_POS  = 4;
  localparam int TBD_TICK_EN_POS   = 3;
  localparam int TBD_TICK_RATE_POS = 0;

  localparam int TBD_HIGH_DIV_W = 23;
  localparam int TBD_LOW_DIV_W  = 15;

  // Divide exponents per select code, element [n] belongs to code n
  localparam logic [7:0][4:0] TBD_TICK_HIGH_EXP = {5'h09, 5'h0B, 5'h0C, 5'h0D,
                                                   5'h0E, 5'h10, 5'h15, 5'h17};
  localparam logic [7:0][4:0] TBD_TICK_LOW_EXP  = {5'h01, 5'h03, 5'h04, 5'h05,
                                                   5'h06, 5'h08, 5'h0D, 5'h0F};
  localparam logic [3:0][4:0] TBD_BUZZ_HIGH_EXP = {5'h0A, 5'h0B, 5'h0C, 5'h0D};
  localparam logic [3:0][4:0] TBD_BUZZ_LOW_EXP  = {5'h02, 5'h03, 5'h04, 5'h05};

  // Highest tick code that has a rate in the low-speed modes
  localparam logic [2:0] TBD_TICK_SLOW_MAX = 3'h1;

  // Idle level of the buzzer pin while the output is off
  localparam logic TBD_BUZZ_IDLE = 1'b1;

  typedef struct packed {
    logic       buzzEn;
    logic [1:0] buzzRate;
    logic       prescale;
    logic       tickEn;
    logic [2:0] tickRate;
  } tbd_ctrl_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } tbd_apb_req_s;

endpackage : tbd_pkg

// >>> core/tbd_timer.sv
/*
  Tick timer and buzzer divider with its APB register slave.
  Assumes clk is the high clock, lowClock is a slow clock level synchronous
  to clk, and lowSpeedMode is high in the low-speed and sleep modes.
*/
// Operation
// - Enabled tick fires on each selected tap fall.
// - Enabling never clears the shared divider.
// - Tick code picks high or low rate.
// - Low-speed modes offer only tick codes 0,1.
// - Enabled buzzer drives roughly 50% duty square.
// - Buzzer enable bit switches pin on/off.
// - Buzzer code picks high or low rate.
// - Prescale picks source; low modes force low clock.
// - One 8-bit control register, resets to zero.
`timescale 1ns/10ps
`default_nettype none

module tbd_timer
  import tbd_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire tbd_pkg::tbd_apb_req_s apbReq,
  output var  logic                  pready,
  output var  logic [31:0]           prdata,
  output var  logic                  pslverr,
  input  wire logic                  lowClock,
  input  wire logic                  lowSpeedMode,
  output var  logic                  tickInterrupt,
  output var  logic                  buzzerOutputPin
);
  import tbd_pkg::*;

  tbd_ctrl_s                   ctrl_q;
  logic                        pready_q;
  logic [31:0]                 prdata_q;
  logic                        pslverr_q;
  logic [TBD_HIGH_DIV_W-1:0]   highCnt_q;
  logic [TBD_LOW_DIV_W-1:0]    lowCnt_q;
  logic                        lowClockPrev_q;
  logic                        tickTapPrev_q;
  logic                        tickInterrupt_q;
  logic                        buzzerOutputPin_q;

  logic                        useLow;
  logic                        tickTapNow;
  logic                        buzzTapNow;
  logic                        tickFall;
  logic                        tickValid;
  logic                        accessPhase;
  logic                        hit;

  ////////////////////////////////////////////////////////////////////////////
  // Tap decoding

  function automatic logic [4:0] tbdTapIndex(input logic [4:0] exponent);
    tbdTapIndex = exponent - 5'h01;
  endfunction : tbdTapIndex

  function automatic logic tbdTap(input logic [4:0]                exponent,
                                  input logic [TBD_HIGH_DIV_W-1:0] cnt);
    tbdTap = cnt[tbdTapIndex(exponent)];
  endfunction : tbdTap

  assign useLow = lowSpeedMode | ctrl_q.prescale;

  assign tickTapNow = useLow
    ? tbdTap(TBD_TICK_LOW_EXP[ctrl_q.tickRate], {8'h00, lowCnt_q})
    : tbdTap(TBD_TICK_HIGH_EXP[ctrl_q.tickRate], highCnt_q);

  assign buzzTapNow = useLow
    ? tbdTap(TBD_BUZZ_LOW_EXP[ctrl_q.buzzRate], {8'h00, lowCnt_q})
    : tbdTap(TBD_BUZZ_HIGH_EXP[ctrl_q.buzzRate], highCnt_q);

  // undefined slow codes give no ticks
  assign tickValid = ~lowSpeedMode | (ctrl_q.tickRate <= TBD_TICK_SLOW_MAX);

  assign tickFall = tickTapPrev_q & ~tickTapNow;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running dividers

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      highCnt_q <= '0;
    else
      highCnt_q <= highCnt_q + {{(TBD_HIGH_DIV_W-1){1'b0}}, 1'b1};
  end

  // Low clock is a synchronous level, so a plain edge detect is enough
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lowClockPrev_q <= 1'b0;
      lowCnt_q       <= '0;
    end
    else
    begin
      lowClockPrev_q <= lowClock;
      if (lowClock & ~lowClockPrev_q)
        lowCnt_q <= lowCnt_q + {{(TBD_LOW_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick interrupt

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickTapPrev_q   <= 1'b0;
      tickInterrupt_q <= 1'b0;
    end
    else
    begin
      tickTapPrev_q   <= tickTapNow;
      tickInterrupt_q <= ctrl_q.tickEn & tickValid & tickFall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buzzer output

  // square wave from a divider bit gives exact 50% duty
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      buzzerOutputPin_q <= TBD_BUZZ_IDLE;
    else if (ctrl_q.buzzEn)
      buzzerOutputPin_q <= buzzTapNow;
    else
      buzzerOutputPin_q <= TBD_BUZZ_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign accessPhase = apbReq.psel & apbReq.penable;
  assign hit         = (apbReq.paddr == TBD_CTRL_ADDR);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= accessPhase & ~pready_q;
      pslverr_q <= accessPhase & ~pready_q & ~hit;
      if (accessPhase & ~pready_q & hit & ~apbReq.pwrite)
        prdata_q <= {24'h0000_00, ctrl_q};
      else
        prdata_q <= '0;
    end
  end

  // control register write
  // Rate fields are taken as written; keeping them stable is up to software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= tbd_ctrl_s'(TBD_CTRL_RESET);
    else if (accessPhase & pready_q & hit & apbReq.pwrite)
      ctrl_q <= tbd_ctrl_s'(apbReq.pwdata[7:0]);
  end

  assign pready          = pready_q;
  assign prdata          = prdata_q;
  assign pslverr         = pslverr_q;
  assign tickInterrupt   = tickInterrupt_q;
  assign buzzerOutputPin = buzzerOutputPin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_apbAccessWait;
    apbReq.psel && apbReq.penable && !pready_q;
  endsequence

  sequence s_apbWriteHit;
    apbReq.psel && apbReq.penable && pready_q && hit && apbReq.pwrite;
  endsequence

  property p_tickNeedsEnable;
    @(posedge clk) disable iff (!rstn)
    tickInterrupt_q |-> $past(ctrl_q.tickEn) && $past(tickTapPrev_q);
  endproperty
  a_tickNeedsEnable: assert property (p_tickNeedsEnable)
    else $error("Tick raised without enable or tap edge");

  property p_tickOnFall;
    @(posedge clk) disable iff (!rstn)
    (ctrl_q.tickEn && tickValid && tickFall) |=> tickInterrupt_q;
  endproperty
  a_tickOnFall: assert property (p_tickOnFall)
    else $error("Tap fell while enabled but no tick");

  property p_dividerFree;
    @(posedge clk) disable iff (!rstn)
    $rose(ctrl_q.tickEn) |-> highCnt_q == $past(highCnt_q) + 23'h00_0001;
  endproperty
  a_dividerFree: assert property (p_dividerFree)
    else $error("Divider disturbed by tick enable");

  property p_fastSlowestTap;
    @(posedge clk) disable iff (!rstn)
    (!useLow && ctrl_q.tickRate == 3'h0) |-> tickTapNow == highCnt_q[22];
  endproperty
  a_fastSlowestTap: assert property (p_fastSlowestTap)
    else $error("Tick code 0 not on high divider bit 22");

  property p_slowCodesSilent;
    @(posedge clk) disable iff (!rstn)
    (lowSpeedMode && ctrl_q.tickRate > 3'h1) |=> !tickInterrupt_q;
  endproperty
  a_slowCodesSilent: assert property (p_slowCodesSilent)
    else $error("Tick from undefined low-speed code");

  property p_buzzFollowsTap;
    @(posedge clk) disable iff (!rstn)
    ctrl_q.buzzEn |=> buzzerOutputPin_q == $past(buzzTapNow);
  endproperty
  a_buzzFollowsTap: assert property (p_buzzFollowsTap)
    else $error("Buzzer pin does not follow its tap");

  property p_buzzIdle;
    @(posedge clk) disable iff (!rstn)
    !ctrl_q.buzzEn [*2] |-> buzzerOutputPin_q == TBD_BUZZ_IDLE;
  endproperty
  a_buzzIdle: assert property (p_buzzIdle)
    else $error("Buzzer pin not idle while disabled");

  property p_lowSourceForced;
    @(posedge clk) disable iff (!rstn)
    (lowSpeedMode && ctrl_q.buzzRate == 2'h3) |-> buzzTapNow == lowCnt_q[1];
  endproperty
  a_lowSourceForced: assert property (p_lowSourceForced)
    else $error("Low-speed mode did not force the low divider");

  property p_writeCommits;
    @(posedge clk) disable iff (!rstn)
    s_apbAccessWait ##1 s_apbWriteHit |=> ctrl_q == $past(apbReq.pwdata[7:0]);
  endproperty
  a_writeCommits: assert property (p_writeCommits)
    else $error("Control write not stored");

  property p_tickSinglePulse;
    @(posedge clk) disable iff (!rstn)
    tickInterrupt_q |=> !tickInterrupt_q;
  endproperty
  a_tickSinglePulse: assert property (p_tickSinglePulse)
    else $error("Tick request longer than one cycle");

  property p_readyAfterWait;
    @(posedge clk) disable iff (!rstn)
    s_apbAccessWait |=> pready_q;
  endproperty
  a_readyAfterWait: assert property (p_readyAfterWait)
    else $error("Access phase not answered after one wait state");

  property p_errOnMiss;
    @(posedge clk) disable iff (!rstn)
    s_apbAccessWait |=> pslverr_q == !$past(hit);
  endproperty
  a_errOnMiss: assert property (p_errOnMiss)
    else $error("Error response does not match the address decode");

  property p_readData;
    @(posedge clk) disable iff (!rstn)
    (apbReq.psel && apbReq.penable && !pready_q && hit && !apbReq.pwrite) |=> prdata_q == {24'h0000_00, $past(ctrl_q)};
  endproperty
  a_readData: assert property (p_readData)
    else $error("Read data does not show the control register");

  property p_lowTickTap;
    @(posedge clk) disable iff (!rstn)
    (useLow && ctrl_q.tickRate == 3'h7) |-> tickTapNow == lowCnt_q[0];
  endproperty
  a_lowTickTap: assert property (p_lowTickTap)
    else $error("Low tick code 7 not on low divider bit 0");

  property p_fastBuzzTap;
    @(posedge clk) disable iff (!rstn)
    (!useLow && ctrl_q.buzzRate == 2'h0) |-> buzzTapNow == highCnt_q[12];
  endproperty
  a_fastBuzzTap: assert property (p_fastBuzzTap)
    else $error("Buzzer code 0 not on high divider bit 12");

endmodule : tbd_timer

`default_nettype wire

// >>> verification/tbd_far_side.sv
/*
  Far-side model: interrupt logic counting tick requests, a buzzer timing
  the pin levels, and the crystal that makes the low clock level.
  Assumes the low clock runs free at one period per 8 clk.
*/
`timescale 1ns/10ps
`default_nettype none
module tbd_far_side (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tickInterrupt,
  input  wire logic buzzerOutputPin,
  output var  logic lowClock,
  output var  int   tickCount,
  output var  int   tickGap,
  output var  int   highRun,
  output var  int   lowRun
);
  logic [1:0] phase_q;
  int         sinceTick_q;
  int         run_q;
  logic       pin_q;
  // A crystal never stops, so the low clock has no idle phase
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {phase_q, lowClock} <= '0;
    else
    begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3)
        lowClock <= ~lowClock;
    end
  // Count pulses and the spacing between them
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {tickCount, tickGap, sinceTick_q} <= '0;
    else if (tickInterrupt)
    begin
      tickCount   <= tickCount + 1;
      tickGap     <= sinceTick_q;
      sinceTick_q <= 1;
    end
    else
      sinceTick_q <= sinceTick_q + 1;
  // Length of the last whole high and low level on the pin
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {highRun, lowRun, run_q, pin_q} <= '0;
    else
    begin
      pin_q <= buzzerOutputPin;
      run_q <= (buzzerOutputPin != pin_q) ? 1 : run_q + 1;
      if (buzzerOutputPin != pin_q && pin_q)
        highRun <= run_q;
      if (buzzerOutputPin != pin_q && !pin_q)
        lowRun <= run_q;
    end
endmodule : tbd_far_side
`default_nettype wire

// >>> verification/tbd_timer_tb.sv
/*
  Self-checking bench for tbd_timer: APB access, tick rates, buzzer rates.
  Assumes tbd_far_side for the low clock and for timing the outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module tbd_timer_tb;
  import tbd_pkg::*;
  logic         clk;
  logic         rstn;
  tbd_apb_req_s req;
  logic         pready;
  logic         pslverr;
  logic         er;
  logic         lowSpeedMode;
  logic         tickInterrupt;
  logic         buzzerOutputPin;
  logic         lowClock;
  logic [31:0]  prdata;
  logic [31:0]  rd;
  int           tickCount, tickGap, highRun, lowRun, base;
  int           numErrors, nCompared;
  int           fastExp[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
  int           lowExp[8]  = '{15, 13, 8, 6, 5, 4, 3, 1};

  tbd_timer tbd_timer_i (.clk(clk), .rstn(rstn), .apbReq(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lowClock(lowClock), .lowSpeedMode(lowSpeedMode),
    .tickInterrupt(tickInterrupt), .buzzerOutputPin(buzzerOutputPin));
  tbd_far_side tbd_far_side_i (.clk(clk), .rstn(rstn), .tickInterrupt(tickInterrupt),
    .buzzerOutputPin(buzzerOutputPin), .lowClock(lowClock), .tickCount(tickCount),
    .tickGap(tickGap), .highRun(highRun), .lowRun(lowRun));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("compared %0d, errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [9:0] ad, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: {24'h0, wd}};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      numErrors++;
      $display("mismatch at %0t: no pready within bound", $time);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] v);
    apb(1'b1, TBD_CTRL_ADDR, v);
  endtask : wr

  task automatic waitTicks(input int n);
    int t0;
    t0 = tickCount;
    for (int i = 0; i < 40000 && tickCount < t0 + n; i++)
      @(posedge clk);
    if (tickCount < t0 + n)
    begin
      numErrors++;
      $display("mismatch at %0t: ticks did not arrive within bound", $time);
      print_verdict();
    end
  endtask : waitTicks
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    req = '0;
    lowSpeedMode = 1'b0;
    numErrors = 0;
    nCompared = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(buzzerOutputPin, 32'h0000_0001);
    apb(1'b1, 10'h0DC, 8'hFF);
    check(er, 32'h0000_0001);
    apb(1'b0, TBD_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_0000);
    wr(8'hA5);
    apb(1'b0, TBD_CTRL_ADDR, 8'h00);
    check(rd, 32'h0000_00A5);
    check(er, 32'h0000_0000);
    wr(8'h25);
    for (int c = 5; c < 8; c++)
    begin
      wr(8'h08 | c[7:0]);
      waitTicks(3);
      check(tickGap, 32'd1 << fastExp[c]);
      wr(c[7:0]);
    end
    for (int c = 2; c < 8; c++)
    begin
      wr(8'h18 | c[7:0]);
      waitTicks(3);
      check(tickGap, 32'd8 << lowExp[c]);
      wr(8'h10 | c[7:0]);
    end
    // A tick launched at the disabling write may still be on its way
    repeat (2) @(posedge clk);
    base = tickCount;
    repeat (200) @(posedge clk);
    check(tickCount, base);
    lowSpeedMode <= 1'b1;
    wr(8'h0F);
    base = tickCount;
    repeat (600) @(posedge clk);
    check(tickCount, base);
    wr(8'h07);
    lowSpeedMode <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr({1'b1, c[1:0], 5'h10});
      repeat (600) @(posedge clk);
      check(highRun, 32'd128 >> c);
      check(lowRun, 32'd128 >> c);
      wr({1'b0, c[1:0], 5'h10});
    end
    wr(8'hE0);
    repeat (2200) @(posedge clk);
    check(highRun, 32'd512);
    wr(8'h60);
    lowSpeedMode <= 1'b1;
    wr(8'hE0);
    repeat (100) @(posedge clk);
    check(lowRun, 32'd16);
    wr(8'h60);
    repeat (40) @(posedge clk);
    check(buzzerOutputPin, 32'h0000_0001);
    print_verdict();
  end
endmodule : tbd_timer_tb
`default_nettype wire
